/* pkg/plsd_pkg.sv */
// plsd_pkg: constants, register map and carrier types of the probe status led driver.
// assumes a 50 MHz aclk and a 32-bit axi4-lite register bus.
package plsd_pkg;

   // clock and prescaler timing
   localparam int unsigned CLK_PERIOD_NS  = 20;
   localparam int unsigned TICK_PERIOD_NS = 1000000;                       // one prescaler tick = 1 ms
   localparam int unsigned TICK_CYCLES    = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // indicator timing: flash rates in Hz, idle limit in seconds, the rest in milliseconds (prescaler ticks)
   localparam int unsigned ENUM_FLASH_HZ  = 10;
   localparam int unsigned FATAL_FLASH_HZ = 1;
   localparam int unsigned ENUM_HALF_MS   = 1000 / (2 * ENUM_FLASH_HZ);
   localparam int unsigned FATAL_HALF_MS  = 1000 / (2 * FATAL_FLASH_HZ);
   localparam int unsigned HB_PERIOD_MS   = 1000;
   localparam int unsigned HB_OFF_MS      = 10;
   localparam int unsigned IDLE_MIN_S     = 7;
   localparam int unsigned IDLE_MIN_MS    = IDLE_MIN_S * 1000;

   // counter widths
   localparam int unsigned PHASE_W = 10;
   localparam int unsigned IDLE_W  = 13;

   // register byte offsets
   localparam logic [7:0] CTRL_OFS     = 8'h00;
   localparam logic [7:0] STATUS_OFS   = 8'h04;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
   localparam logic [7:0] ID_OFS       = 8'h10;

   // control register fields
   localparam int unsigned CTRL_ENUM_BIT   = 0;
   localparam int unsigned CTRL_BUSY_BIT   = 1;
   localparam int unsigned CTRL_FATAL_BIT  = 2;
   localparam int unsigned CTRL_SUPPLY_BIT = 3;
   localparam int unsigned CTRL_DRIVE_BIT  = 4;
   localparam int unsigned CTRL_W          = 5;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h01;                     // enumerating after reset

   // interrupt status fields
   localparam int unsigned IRQ_HB_BIT   = 0;
   localparam int unsigned IRQ_TRST_BIT = 1;
   localparam int unsigned IRQ_VDET_BIT = 2;
   localparam int unsigned IRQ_W        = 3;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 3'h0;

   // axi response codes
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // one bi-colour indicator: both lit reads as orange
   typedef struct packed {
      logic green;
      logic red;
   } plsd_led_s;

   // all three indicators together
   typedef struct packed {
      plsd_led_s main_led;
      plsd_led_s in_led;
      plsd_led_s out_led;
   } plsd_leds_s;

   // probe state as written by firmware
   typedef struct packed {
      logic drive_reset;
      logic supply_en;
      logic fatal;
      logic cmd_busy;
      logic enumerating;
   } plsd_ctrl_s;

   // main indicator pattern selected by priority
   typedef enum logic [2:0] {
      MAIN_FATAL = 3'b000,
      MAIN_TRST  = 3'b001,
      MAIN_ENUM  = 3'b010,
      MAIN_BUSY  = 3'b011,
      MAIN_HB    = 3'b100,
      MAIN_IDLE  = 3'b101
   } plsd_main_e;

endpackage : plsd_pkg

/* rtl/plsd_tick_gen.sv */
// plsd_tick_gen: prescaler giving a one-cycle tick every TICK_CYCLES clocks.
// assumes a free-running aclk; count restarts on synchronous reset.
`timescale 1ns/1ns
module plsd_tick_gen #(
   parameter int unsigned TICK_CYCLES = 50000
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   output logic      tick
);
   localparam int unsigned CNT_W = $clog2(TICK_CYCLES + 1);

   logic [CNT_W-1:0] count;

   // refuse a prescaler that cannot divide
   if (TICK_CYCLES < 1) begin : g_bad_div
      $error("plsd_tick_gen: TICK_CYCLES must be at least 1");
   end

   // divider; tick on the last count keeps the period exact
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count <= '0;
         tick  <= 1'b0;
      end else if (count == CNT_W'(TICK_CYCLES - 1)) begin
         count <= '0;
         tick  <= 1'b1;
      end else begin
         count <= count + CNT_W'(1);
         tick  <= 1'b0;
      end
   end

endmodule : plsd_tick_gen

/* rtl/plsd_led_driver.sv */
// plsd_led_driver: main, input and output status indicators of a debug probe, with an
// axi4-lite register file for probe state, indicator readback and interrupts.
// assumes firmware writes probe state into the control register; target pins are asynchronous.
//
// Behaviour
// - while enumerating the main indicator flashes green at 10 Hz.
// - in operation the main indicator is green but dark while each command executes.
// - enumerated with no command executing, the main indicator is steady green.
// - after seven seconds of idle the green indicator blanks for 10 ms once per second.
// - on a fatal error the main indicator flashes at 1 Hz, green on single colour and red on bi-colour.
// - on the bi-colour variant the main indicator is orange while reset is active on the target.
// - the bi-colour main indicator uses a green and a red led, older variants drive green only.
// - the input indicator is green with target voltage present and target reset high.
// - the input indicator is orange with target voltage present and target reset low.
// - the input indicator is red with target reset low and no target voltage.
// - the output indicator is dark with supply off and green with supply on while not driving reset.
// - while the probe drives target reset the output indicator is orange with supply on, red without.
`timescale 1ns/1ns
module plsd_led_driver
   import plsd_pkg::*;
#(
   parameter bit          BI_COLOR    = 1'b1,
   parameter int unsigned TICK_CYCLES = plsd_pkg::TICK_CYCLES,
   parameter logic [31:0] ID_VALUE    = 32'h0000_5A5A          // arbitrary value
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite slave
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // target side pins
   input  wire logic        tgt_vdet,
   input  wire logic        tgt_reset_n,
   output logic             tgt_supply_en,
   output logic             tgt_reset_drive,
   // indicators and interrupt
   output plsd_leds_s       leds,
   output logic             irq
);

   // true during the lit half of a blink period
   function automatic logic blink_on(input logic [PHASE_W-1:0] phase, input int unsigned half_ms);
      int unsigned p;
      p = 32'(phase) % (2 * half_ms);
      return p < half_ms;
   endfunction : blink_on

   // byte-lane merge of a write into a register word
   function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] strb);
      logic [31:0] r;
      for (int i = 0; i < 4; i++) begin
         r[i*8 +: 8] = strb[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
      end
      return r;
   endfunction : merge_strb

   logic                   tick;
   logic [1:0]             vdet_sync;
   logic [1:0]             trst_sync;
   logic                   vdet;
   logic                   trst_low;
   logic                   vdet_d;
   logic                   trst_low_d;
   plsd_ctrl_s             ctrl;
   logic [IRQ_W-1:0]       irq_stat;
   logic [IRQ_W-1:0]       irq_mask;
   logic [IRQ_W-1:0]       irq_event;
   logic [PHASE_W-1:0]     phase;
   logic [IDLE_W-1:0]      idle_cnt;
   logic                   idle;
   logic                   hb_active;
   logic                   hb_active_d;
   plsd_main_e             main_sel;
   plsd_led_s              next_main;
   logic                   aw_full;
   logic                   w_full;
   logic [7:0]             aw_addr;
   logic [31:0]            w_data;
   logic [3:0]             w_strb;
   logic                   wr_fire;
   logic [31:0]            ctrl_word;
   logic [31:0]            status_word;
   logic [31:0]            rd_word;
   logic                   rd_hit;

   // millisecond prescaler
   plsd_tick_gen #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_tick (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (tick)
   );

   // target pins cross into aclk through two flops each
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         vdet_sync <= 2'h0;
         trst_sync <= 2'h3;
      end else begin
         vdet_sync <= {vdet_sync[0], tgt_vdet};
         trst_sync <= {trst_sync[0], tgt_reset_n};
      end
   end

   assign vdet     = vdet_sync[1];
   assign trst_low = ~trst_sync[1];   // a floating, unconnected target also reads as low

   // free-running blink phase, 0..999 ms
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase <= '0;
      end else if (tick) begin
         if (phase == PHASE_W'(HB_PERIOD_MS - 1)) begin
            phase <= '0;
         end else begin
            phase <= phase + PHASE_W'(1);
         end
      end
   end

   // idle means enumerated, no command and no fault
   assign idle = ~ctrl.enumerating & ~ctrl.cmd_busy & ~ctrl.fatal;

   // idle timer saturates so the heartbeat stays on until activity
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         idle_cnt <= '0;
      end else if (!idle) begin
         idle_cnt <= '0;
      end else if (tick && idle_cnt != IDLE_W'(IDLE_MIN_MS)) begin
         idle_cnt <= idle_cnt + IDLE_W'(1);
      end
   end

   assign hb_active = idle & (idle_cnt == IDLE_W'(IDLE_MIN_MS));

   // main pattern chosen in fixed priority order
   always_comb begin
      if (ctrl.fatal) begin
         main_sel = MAIN_FATAL;
      end else if (BI_COLOR && trst_low) begin
         main_sel = MAIN_TRST;
      end else if (ctrl.enumerating) begin
         main_sel = MAIN_ENUM;
      end else if (ctrl.cmd_busy) begin
         main_sel = MAIN_BUSY;
      end else if (hb_active) begin
         main_sel = MAIN_HB;
      end else begin
         main_sel = MAIN_IDLE;
      end
   end

   // main indicator colour for the chosen pattern
   always_comb begin
      next_main = '{green: 1'b0, red: 1'b0};
      case (main_sel)
         MAIN_FATAL: begin
            next_main.red   = BI_COLOR & blink_on(phase, FATAL_HALF_MS);
            next_main.green = ~BI_COLOR & blink_on(phase, FATAL_HALF_MS);
         end
         MAIN_TRST:  next_main = '{green: 1'b1, red: 1'b1};
         MAIN_ENUM:  next_main.green = blink_on(phase, ENUM_HALF_MS);
         MAIN_BUSY:  next_main.green = 1'b0;
         MAIN_HB:    next_main.green = (phase >= PHASE_W'(HB_OFF_MS));
         MAIN_IDLE:  next_main.green = 1'b1;
         default:    next_main = '{green: 1'b0, red: 1'b0};
      endcase
   end

   // indicator flops; single-colour builds never light a red led and have no input or output indicator
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         leds <= '0;
      end else begin
         leds.main_led.green <= next_main.green;
         leds.main_led.red   <= BI_COLOR & next_main.red;
         leds.in_led         <= BI_COLOR ? {vdet, trst_low} : 2'h0;
         leds.out_led        <= BI_COLOR ? {ctrl.supply_en, ctrl.drive_reset} : 2'h0;
      end
   end

   // probe pins follow the control register
   assign tgt_supply_en   = ctrl.supply_en;
   assign tgt_reset_drive = ctrl.drive_reset;

   // edge history for interrupt events
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         vdet_d      <= 1'b0;
         trst_low_d  <= 1'b0;
         hb_active_d <= 1'b0;
      end else begin
         vdet_d      <= vdet;
         trst_low_d  <= trst_low;
         hb_active_d <= hb_active;
      end
   end

   // events: heartbeat entered, target reset went low, target voltage changed
   always_comb begin
      irq_event               = '0;
      irq_event[IRQ_HB_BIT]   = hb_active & ~hb_active_d;
      irq_event[IRQ_TRST_BIT] = trst_low & ~trst_low_d;
      irq_event[IRQ_VDET_BIT] = vdet ^ vdet_d;
   end

   // write channel acceptance; aw and w may arrive in either order
   assign s_axi_awready = ~aw_full & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_full & ~s_axi_bvalid;
   assign wr_fire       = aw_full & w_full & ~s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         aw_addr <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_full <= 1'b1;
         aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
         aw_full <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_full <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_full <= 1'b1;
         w_data <= s_axi_wdata;
         w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
         w_full <= 1'b0;
      end
   end

   // write response, slverr for an unmapped or read-only word
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= (aw_addr == CTRL_OFS || aw_addr == IRQ_STAT_OFS || aw_addr == IRQ_MASK_OFS)
                         ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   assign ctrl_word = {{(32-CTRL_W){1'b0}}, ctrl};

   // control register steers the indicator logic
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= CTRL_RESET;
      end else if (wr_fire && aw_addr == CTRL_OFS) begin
         ctrl <= CTRL_W'(merge_strb(ctrl_word, w_data, w_strb));
      end
   end

   // interrupt mask
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_mask <= IRQ_MASK_RESET;
      end else if (wr_fire && aw_addr == IRQ_MASK_OFS && w_strb[0]) begin
         irq_mask <= w_data[IRQ_W-1:0];
      end
   end

   // sticky status, write one to clear; a new event wins over a clear in the same cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat <= '0;
      end else if (wr_fire && aw_addr == IRQ_STAT_OFS && w_strb[0]) begin
         irq_stat <= (irq_stat & ~w_data[IRQ_W-1:0]) | irq_event;
      end else begin
         irq_stat <= irq_stat | irq_event;
      end
   end

   assign irq = |(irq_stat & irq_mask);

   // readback of indicator and pin state
   assign status_word = {23'h0, hb_active, vdet, trst_low, leds};

   always_comb begin
      rd_hit  = 1'b1;
      rd_word = 32'h0000_0000;
      case (s_axi_araddr)
         CTRL_OFS:     rd_word = ctrl_word;
         STATUS_OFS:   rd_word = status_word;
         IRQ_STAT_OFS: rd_word = {{(32-IRQ_W){1'b0}}, irq_stat};
         IRQ_MASK_OFS: rd_word = {{(32-IRQ_W){1'b0}}, irq_mask};
         ID_OFS:       rd_word = ID_VALUE;
         default:      rd_hit  = 1'b0;
      endcase
   end

   // read channel, one read under way at a time
   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule : plsd_led_driver

/* verification/plsd_target_model.sv */
// plsd_target_model: target board seen from the probe pins: voltage sense and reset line.
// assumes the bench decides whether a board is present and whether it holds its own reset.
`timescale 1ns/1ns
module plsd_target_model (
   input  wire logic connected,
   input  wire logic pull_low,
   input  wire logic tgt_reset_drive,
   output logic      tgt_vdet,
   output logic      tgt_reset_n
);
   // sense follows board presence; the reset line has a pull-down, so no board reads as reset
   assign tgt_vdet    = connected;
   assign tgt_reset_n = connected && !pull_low && !tgt_reset_drive;
endmodule : plsd_target_model

/* verification/plsd_led_monitor.sv */
// plsd_led_monitor: bus handshake and indicator checks on the status led driver ports.
// assumes aclk at 50 MHz and aresetn synchronous active low; bound into every driver instance.
`timescale 1ns/1ns
module plsd_led_monitor
   import plsd_pkg::*;
(
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        tgt_vdet,
   input wire logic        tgt_reset_n,
   input wire logic        tgt_supply_en,
   input wire logic        tgt_reset_drive,
   input wire plsd_leds_s  leds
);
   logic [2:0] since_rst;

   // cycles since reset, saturating; pin history from before release means nothing
   always_ff @(posedge aclk) begin
      if (!aresetn) since_rst <= 3'h0;
      else if (since_rst != 3'h7) since_rst <= since_rst + 3'h1;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response changed before it was taken");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data changed before it was taken");
   a_ar_refused: assert property (s_axi_arready == !s_axi_rvalid)
      else $error("read address ready disagrees with pending read data");
   a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while a response is pending");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rresp != 2'h1)
      else $error("read answer late or bad code");
   a_resp_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_out_led: assert property (leds.out_led == {$past(tgt_supply_en), $past(tgt_reset_drive)})
      else $error("output indicator does not follow supply and reset drive");
   a_in_green: assert property (since_rst > 3'h4 |-> leds.in_led.green == $past(tgt_vdet, 3))
      else $error("input indicator green does not follow target voltage");
   a_in_red: assert property (since_rst > 3'h4 |-> leds.in_led.red == !$past(tgt_reset_n, 3))
      else $error("input indicator red does not follow target reset");
endmodule : plsd_led_monitor

bind plsd_led_driver plsd_led_monitor u_mon (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .tgt_vdet(tgt_vdet), .tgt_reset_n(tgt_reset_n),
   .tgt_supply_en(tgt_supply_en), .tgt_reset_drive(tgt_reset_drive), .leds(leds));

/* verification/testbench.sv */
// testbench: register-driven scenarios for the probe status led driver with a target model.
// assumes a 1 ms prescaler tick shortened to TICKS clocks; all timing expectations scale with it.
`timescale 1ns/1ns
module testbench;
   import plsd_pkg::*;
   localparam int unsigned TICKS  = 5;
   localparam logic [31:0] ID_EXP = 32'h0000_00C3;           // arbitrary value
   localparam int          P      = HB_PERIOD_MS * TICKS;    // one second in clocks
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0]  bresp, rresp;
   logic        tgt_vdet, tgt_reset_n, tgt_supply_en, tgt_reset_drive;
   logic        connected = 1'b1, pull_low = 1'b0;
   plsd_leds_s  leds;
   int          num_errors = 0, tests_run = 0, cycles = 0;

   always #10 aclk = ~aclk;

   plsd_led_driver #(.BI_COLOR(1'b1), .TICK_CYCLES(TICKS), .ID_VALUE(ID_EXP)) uut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .tgt_vdet(tgt_vdet), .tgt_reset_n(tgt_reset_n),
      .tgt_supply_en(tgt_supply_en), .tgt_reset_drive(tgt_reset_drive), .leds(leds), .irq(irq));

   plsd_target_model u_tgt (.connected(connected), .pull_low(pull_low), .tgt_reset_drive(tgt_reset_drive),
      .tgt_vdet(tgt_vdet), .tgt_reset_n(tgt_reset_n));

   task automatic final_report;
      $display("checks %0d, mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : final_report

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // write: address and data offered together, each dropped once taken, bready held till bvalid
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      check("bresp", 32'(bresp), 32'(er));
      bready <= 1'b0;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      check("rdata", rdata, exp);
      check("rresp", 32'(rresp), 32'(er));
      rready <= 1'b0;
   endtask : axi_rd

   // counts lit cycles of each main colour and dark-to-lit changes over n clocks
   task automatic main_led_is(input int n, input int eg, input int er, input int eri);
      int   lg, lr, ri;
      logic prev, cur;
      lg = 0;
      lr = 0;
      ri = 0;
      repeat (2) @(posedge aclk);
      #1;
      prev = leds.main_led.green | leds.main_led.red;
      repeat (n) begin
         @(posedge aclk);
         #1;
         cur = leds.main_led.green | leds.main_led.red;
         if (leds.main_led.green === 1'b1) lg++;
         if (leds.main_led.red === 1'b1) lr++;
         if (cur === 1'b1 && prev === 1'b0) ri++;
         prev = cur;
      end
      check("main green cycles", 32'(lg), 32'(eg));
      check("main red cycles", 32'(lr), 32'(er));
      check("main flashes", 32'(ri), 32'(eri));
   endtask : main_led_is

   // hang guard, well above the roughly 56000 clocks the sequence needs
   always @(posedge aclk) begin
      cycles++;
      if (cycles == 90000) begin
         num_errors++;
         final_report();
      end
   end

   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(CTRL_OFS, 32'h01);
      axi_rd(ID_OFS, ID_EXP);
      axi_rd(8'h14, 32'h0, RESP_SLVERR);
      axi_wr(8'h14, 32'h1F, RESP_SLVERR);
      axi_wr(STATUS_OFS, 32'h0, RESP_SLVERR);
      axi_rd(CTRL_OFS, 32'h01);
      check("in_led", 32'(leds.in_led), 32'h2);
      main_led_is(P, ENUM_HALF_MS * TICKS * ENUM_FLASH_HZ, 0, ENUM_FLASH_HZ);
      // fatal over target reset over enumeration and busy
      pull_low <= 1'b1;
      axi_wr(CTRL_OFS, 32'h07);
      check("in_led", 32'(leds.in_led), 32'h3);
      main_led_is(P, 0, FATAL_HALF_MS * TICKS, FATAL_FLASH_HZ);
      axi_wr(CTRL_OFS, 32'h03);
      main_led_is(100, 100, 100, 0);
      pull_low  <= 1'b0;
      connected <= 1'b0;
      repeat (6) @(posedge aclk);
      #1;
      check("in_led", 32'(leds.in_led), 32'h1);
      connected <= 1'b1;
      axi_wr(CTRL_OFS, 32'h02);
      main_led_is(100, 0, 0, 0);
      axi_wr(CTRL_OFS, 32'h00);
      main_led_is(100, 100, 0, 0);
      for (int i = 0; i < 4; i++) begin
         axi_wr(CTRL_OFS, 32'(i << 3));
         axi_rd(CTRL_OFS, 32'(i << 3));
         repeat (5) @(posedge aclk);
         #1;
         check("supply", 32'(tgt_supply_en), 32'(i[0]));
         check("reset drive", 32'(tgt_reset_drive), 32'(i[1]));
         check("out_led", 32'(leds.out_led), 32'({i[0], i[1]}));
         check("in_led", 32'(leds.in_led), 32'({1'b1, i[1]}));
      end
      // idle from here; heartbeat interrupt armed
      axi_wr(CTRL_OFS, 32'h00);
      axi_rd(IRQ_STAT_OFS, 32'h6);
      axi_wr(IRQ_STAT_OFS, 32'h7);
      axi_wr(IRQ_MASK_OFS, 32'h1);
      axi_rd(IRQ_STAT_OFS, 32'h0);
      check("irq", 32'(irq), 32'h0);
      main_led_is(P, P, 0, 0);
      axi_rd(STATUS_OFS, 32'h0000_00A8);
      repeat ((IDLE_MIN_MS - 3 * HB_PERIOD_MS) * TICKS) @(posedge aclk);
      main_led_is(P, P, 0, 0);
      repeat (2 * P) @(posedge aclk);
      main_led_is(P, P - HB_OFF_MS * TICKS, 0, 1);
      check("irq", 32'(irq), 32'h1);
      axi_rd(IRQ_STAT_OFS, 32'h1);
      axi_wr(IRQ_MASK_OFS, 32'h0);
      #1;
      check("irq", 32'(irq), 32'h0);
      axi_rd(IRQ_STAT_OFS, 32'h1);
      axi_wr(IRQ_STAT_OFS, 32'h1);
      axi_rd(IRQ_STAT_OFS, 32'h0);
      axi_wr(IRQ_MASK_OFS, 32'h1);
      #1;
      check("irq", 32'(irq), 32'h0);
      final_report();
   end
endmodule : testbench
